// File: logic/bra_decoder_top.sv
// First-level address decoder with boot select and remap
// How it works
// R1: Top four address bits pick one of sixteen 256-Mbyte banks.
// R2: Banks 1 to 7 go to the external port with their chip select.
// R3: Bank 0 holds internal memories in 1-Mbyte second-level regions.
// R4: Bank 15 goes to the peripheral bridge.
// R5: Unoccupied regions answer with an abort.
// R6: Every master has its own decoder; only processor masters see remap.
// R7: For processor masters address zero maps to ROM, external or SRAM.
// R8: After reset with boot pin high, ROM is seen at zero and at its 1-Mbyte base.
// R9: Remap set puts the first 4K SRAM at zero for processors.
// R10: Remap clear: boot pin high gives ROM at zero, low gives chip select 0.
// R11: The first Mbyte is reserved for the boot alias.
// R12: External boot gives static controller byte select, 16 bits, CS strobes.
// R13: Each external chip select owns its own 256-Mbyte window.
// R14: Chip selects 0 to 6 decoded, each assignable to static or SDRAM control.
// R15: System controller decoded from 0xFFFFE800 to the top.
// R16: Remap changes apply to the next request; clearing restores boot map.
`timescale 1ns/100ps
`default_nettype none
`include "bra_cfg.svh"
module bra_decoder_top
    import bra_pkg::*;
#(
    parameter int NUM_MASTERS = 2,
    parameter int NUM_PROC = 2
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic BOOT_MEMORY_SELECT_IN,
    input wire logic REMAP_IN,
    input wire logic [7:0] CS_SDRAM_ASSIGN_IN,
    input wire logic [NUM_MASTERS-1:0] REQ_IN,
    input wire logic [NUM_MASTERS-1:0][31:0] ADDR_IN,
    output logic BOOT_READY_OUT,
    output logic BOOT_FROM_ROM_OUT,
    output logic STATIC_MEM_CTRL_BYTE_SEL_OUT,
    output logic [1:0] STATIC_MEM_CTRL_WIDTH_OUT,
    output logic STATIC_MEM_CTRL_RW_CS_OUT,
    output logic [NUM_MASTERS-1:0] DEC_VALID_OUT,
    output logic [NUM_MASTERS-1:0][2:0] SLAVE_OUT,
    output logic [NUM_MASTERS-1:0][7:0] CS_OUT,
    output logic [NUM_MASTERS-1:0] SDRAM_OUT,
    output logic [NUM_MASTERS-1:0] SYSC_OUT,
    output logic [NUM_MASTERS-1:0] ABORT_OUT,
    output logic [NUM_MASTERS-1:0][31:0] LOCAL_ADDR_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    // ----------------------------------------
    // Boot pin synchroniser and capture
    // ----------------------------------------
    logic boot_sel_sync1_reg;
    logic boot_sel_sync2_reg;
    bra_boot_state_t boot_state_reg;

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            boot_sel_sync1_reg <= 1'b0;
            boot_sel_sync2_reg <= 1'b0;
        end else begin
            boot_sel_sync1_reg <= BOOT_MEMORY_SELECT_IN;
            boot_sel_sync2_reg <= boot_sel_sync1_reg;
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            boot_state_reg <= BRA_BS_FILL0;
            BOOT_READY_OUT <= 1'b0;
            BOOT_FROM_ROM_OUT <= 1'b0;
        end else begin
            case (boot_state_reg)
                BRA_BS_FILL0: begin
                    boot_state_reg <= BRA_BS_FILL1;
                end
                BRA_BS_FILL1: begin
                    boot_state_reg <= BRA_BS_LATCH;
                end
                BRA_BS_LATCH: begin
                    BOOT_FROM_ROM_OUT <= boot_sel_sync2_reg; // R10
                    BOOT_READY_OUT <= 1'b1;
                    boot_state_reg <= BRA_BS_DONE;
                end
                BRA_BS_DONE: begin
                    boot_state_reg <= BRA_BS_DONE;
                end
                default: begin
                    boot_state_reg <= BRA_BS_FILL0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Static controller boot defaults
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            STATIC_MEM_CTRL_BYTE_SEL_OUT <= 1'b0;
            STATIC_MEM_CTRL_WIDTH_OUT <= `BRA_STATIC_WIDTH_RST;
            STATIC_MEM_CTRL_RW_CS_OUT <= 1'b0;
        end else if (boot_state_reg == BRA_BS_LATCH) begin
            STATIC_MEM_CTRL_BYTE_SEL_OUT <= !boot_sel_sync2_reg; // R12
            STATIC_MEM_CTRL_RW_CS_OUT <= !boot_sel_sync2_reg; // R12
            if (!boot_sel_sync2_reg) begin
                STATIC_MEM_CTRL_WIDTH_OUT <= `BRA_STATIC_WIDTH_16; // R12
            end
        end
    end

    // ----------------------------------------
    // One decoder per master
    // ----------------------------------------
    for (genvar g = 0; g < NUM_MASTERS; g++) begin : gen_master
        bra_dec_if dif ();

        assign dif.addr = ADDR_IN[g];
        assign dif.remap = REMAP_IN; // R16
        assign dif.boot_rom = BOOT_FROM_ROM_OUT;
        assign dif.cs_sdram = CS_SDRAM_ASSIGN_IN;

        bra_master_decode #(
            .IS_PROC(g < NUM_PROC)
        ) u_dec (
            .dif(dif.dec) // R6
        );

        always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                DEC_VALID_OUT[g] <= 1'b0;
                SLAVE_OUT[g] <= 3'h0;
                CS_OUT[g] <= 8'h00;
                SDRAM_OUT[g] <= 1'b0;
                SYSC_OUT[g] <= 1'b0;
                ABORT_OUT[g] <= 1'b0;
                LOCAL_ADDR_OUT[g] <= 32'h0000_0000;
            end else begin
                DEC_VALID_OUT[g] <= REQ_IN[g] && BOOT_READY_OUT;
                if (REQ_IN[g] && BOOT_READY_OUT) begin
                    SLAVE_OUT[g] <= dif.slave; // R1
                    CS_OUT[g] <= dif.cs;
                    SDRAM_OUT[g] <= dif.sdram;
                    SYSC_OUT[g] <= dif.sysc;
                    ABORT_OUT[g] <= dif.abort; // R5
                    LOCAL_ADDR_OUT[g] <= dif.local_addr;
                end else begin
                    CS_OUT[g] <= 8'h00;
                    ABORT_OUT[g] <= 1'b0;
                end
            end
        end

        // ------------------------------------
        // Checks
        // ------------------------------------
        sequence s_take;
            REQ_IN[g] && BOOT_READY_OUT;
        endsequence
        sequence s_bank(logic [3:0] lo, logic [3:0] hi);
            ADDR_IN[g][31:28] >= lo && ADDR_IN[g][31:28] <= hi;
        endsequence

        AST_EXT_CS: assert property ( // R2
            s_take ##0 s_bank(4'h1, 4'h7) |=> DEC_VALID_OUT[g] &&
            SLAVE_OUT[g] == BRA_SLV_EXT && !ABORT_OUT[g] &&
            CS_OUT[g] == (8'h01 << ($past(ADDR_IN[g][30:28]) - 3'h1)))
            else $error("external bank gave wrong chip select");
        AST_EXT_WINDOW: assert property ( // R13
            s_take ##0 s_bank(4'h1, 4'h7) |=>
            LOCAL_ADDR_OUT[g] == {4'h0, $past(ADDR_IN[g][27:0])})
            else $error("external window offset wrong");
        AST_SDRAM_ASSIGN: assert property ( // R14
            s_take ##0 s_bank(4'h1, 4'h7) |=> SDRAM_OUT[g] ==
            $past(CS_SDRAM_ASSIGN_IN[ADDR_IN[g][30:28] - 3'h1]))
            else $error("chip select assignment ignored");
        AST_PERIPH: assert property ( // R4
            s_take ##0 s_bank(4'hF, 4'hF) |=>
            SLAVE_OUT[g] == BRA_SLV_APB && !ABORT_OUT[g])
            else $error("bank 15 not sent to bridge");
        AST_SYSC: assert property ( // R15
            s_take ##0 (ADDR_IN[g] >= 32'hFFFF_E800) |=> SYSC_OUT[g])
            else $error("system controller range missed");
        AST_UNMAPPED: assert property ( // R5
            s_take ##0 s_bank(4'h8, 4'hE) |=>
            ABORT_OUT[g] && SLAVE_OUT[g] == BRA_SLV_NONE)
            else $error("unmapped bank not aborted");
        AST_ROM_BASE: assert property ( // R8
            s_take ##0 (ADDR_IN[g][31:15] == 17'h0_0020) |=>
            SLAVE_OUT[g] == BRA_SLV_ROM)
            else $error("ROM not at its base");
        AST_NO_REQ: assert property ( // R16
            !REQ_IN[g] |=> !DEC_VALID_OUT[g] && !ABORT_OUT[g])
            else $error("result without request");
        AST_TAKEN: assert property ( // R1
            s_take |=> DEC_VALID_OUT[g])
            else $error("taken request gave no result");
        AST_EARLY: assert property ( // R8
            !BOOT_READY_OUT |=> !DEC_VALID_OUT[g])
            else $error("request taken before boot capture");
        if (g < NUM_PROC) begin : gen_proc
            AST_REMAP_SRAM: assert property ( // R9
                s_take ##0 REMAP_IN ##0 (ADDR_IN[g][31:12] == 20'h0_0000)
                |=> SLAVE_OUT[g] == BRA_SLV_FIRST_SRAM)
                else $error("remap did not give SRAM at zero");
            AST_BOOT_ALIAS: assert property ( // R10
                s_take ##0 !REMAP_IN ##0 (ADDR_IN[g][31:20] == 12'h000)
                ##0 !BOOT_FROM_ROM_OUT |=>
                SLAVE_OUT[g] == BRA_SLV_EXT && CS_OUT[g] == 8'h01)
                else $error("external boot alias wrong");
            AST_ROM_ALIAS: assert property ( // R11
                s_take ##0 !REMAP_IN ##0 (ADDR_IN[g][31:15] == 17'h0_0000)
                ##0 BOOT_FROM_ROM_OUT |=> SLAVE_OUT[g] == BRA_SLV_ROM)
                else $error("boot ROM alias at zero missed");
        end
    end

    AST_BOOT_STABLE: assert property ( // R12
        BOOT_READY_OUT |=> BOOT_READY_OUT && $stable(BOOT_FROM_ROM_OUT) &&
        (BOOT_FROM_ROM_OUT ||
        STATIC_MEM_CTRL_WIDTH_OUT == `BRA_STATIC_WIDTH_16))
        else $error("boot selection changed after capture");
endmodule
`default_nettype wire

// File: logic/bra_master_decode.sv
// Combinational address decoder for one bus master
`timescale 1ns/100ps
`default_nettype none
`include "bra_cfg.svh"
module bra_master_decode
    import bra_pkg::*;
#(
    parameter bit IS_PROC = 1'b1
) (
    bra_dec_if.dec dif
);
    logic [3:0] bank;
    logic [7:0] sub;
    logic [19:0] off;
    logic [2:0] cs_idx;

    assign bank = dif.addr[31:28];
    assign sub = dif.addr[27:20];
    assign off = dif.addr[19:0];
    assign cs_idx = 3'(bank - `BRA_BANK_EXT_FIRST);

    // ----------------------------------------
    // Bank and region decode
    // ----------------------------------------
    always_comb begin
        dif.slave = BRA_SLV_NONE;
        dif.cs = 8'h00;
        dif.sdram = 1'b0;
        dif.sysc = 1'b0;
        dif.abort = 1'b1;
        dif.local_addr = 32'h0000_0000;
        if (bank == `BRA_BANK_INT) begin
            dif.local_addr = dif.addr & `BRA_REGION_MASK;
            case (sub)
                `BRA_SUB_ALIAS: begin // R11
                    // Boot alias at zero
                    if (IS_PROC && dif.remap) begin // R7
                        if (off < `BRA_SRAM_SIZE) begin
                            dif.slave = BRA_SLV_FIRST_SRAM; // R9
                            dif.abort = 1'b0;
                        end
                    end else if (dif.boot_rom) begin
                        if (off < `BRA_ROM_SIZE) begin
                            dif.slave = BRA_SLV_ROM; // R10
                            dif.abort = 1'b0;
                        end
                    end else begin
                        dif.slave = BRA_SLV_EXT; // R10
                        dif.cs = 8'h01;
                        dif.sdram = dif.cs_sdram[0];
                        dif.abort = 1'b0;
                    end
                end
                `BRA_SUB_ROM: begin
                    if (off < `BRA_ROM_SIZE) begin
                        dif.slave = BRA_SLV_ROM; // R8
                        dif.abort = 1'b0;
                    end
                end
                `BRA_SUB_FIRST_SRAM: begin
                    if (off < `BRA_SRAM_SIZE) begin
                        dif.slave = BRA_SLV_FIRST_SRAM; // R3
                        dif.abort = 1'b0;
                    end
                end
                `BRA_SUB_SRAM1: begin
                    if (off < `BRA_SRAM_SIZE) begin
                        dif.slave = BRA_SLV_SRAM1; // R3
                        dif.abort = 1'b0;
                    end
                end
                default: begin
                    dif.slave = BRA_SLV_NONE; // R5
                end
            endcase
        end else if (bank >= `BRA_BANK_EXT_FIRST &&
                     bank <= `BRA_BANK_EXT_LAST) begin
            dif.slave = BRA_SLV_EXT; // R2
            dif.cs = 8'h01 << cs_idx; // R13
            dif.sdram = dif.cs_sdram[cs_idx]; // R14
            dif.abort = 1'b0;
            dif.local_addr = {4'h0, dif.addr[27:0]};
        end else if (bank == `BRA_BANK_PERIPH) begin
            dif.slave = BRA_SLV_APB; // R4
            dif.sysc = (dif.addr >= `BRA_SYSC_BASE); // R15
            dif.abort = 1'b0;
            dif.local_addr = dif.addr;
        end
    end
endmodule
`default_nettype wire

// File: pkg/bra_cfg.svh
// Address map constants for the boot and remap address decoder
`ifndef BRA_CFG_SVH
`define BRA_CFG_SVH

// ----------------------------------------
// Bank decode on address bits 31..28
// ----------------------------------------
`define BRA_BANK_INT 4'h0
`define BRA_BANK_EXT_FIRST 4'h1
`define BRA_BANK_EXT_LAST 4'h7
`define BRA_BANK_PERIPH 4'hF

// ----------------------------------------
// Second level inside bank 0, bits 27..20
// ----------------------------------------
`define BRA_SUB_ALIAS 8'h00
`define BRA_SUB_ROM 8'h01
`define BRA_SUB_FIRST_SRAM 8'h02
`define BRA_SUB_SRAM1 8'h03
`define BRA_REGION_MASK 32'h000F_FFFF
`define BRA_ROM_SIZE 20'h0_8000
`define BRA_SRAM_SIZE 20'h0_1000

// ----------------------------------------
// Peripheral bank and system controller
// ----------------------------------------
`define BRA_SYSC_BASE 32'hFFFF_E800

// ----------------------------------------
// Static controller defaults for external boot
// ----------------------------------------
`define BRA_STATIC_WIDTH_16 2'h1
`define BRA_STATIC_WIDTH_RST 2'h0

`endif

// File: pkg/bra_dec_if.sv
// Per-master decode request and result bundle
`timescale 1ns/100ps
`default_nettype none
interface bra_dec_if;
    import bra_pkg::*;
    logic [31:0] addr;
    logic remap;
    logic boot_rom;
    logic [7:0] cs_sdram;
    bra_slave_t slave;
    logic [7:0] cs;
    logic sdram;
    logic sysc;
    logic abort;
    logic [31:0] local_addr;

    modport ctl (
        output addr, remap, boot_rom, cs_sdram,
        input slave, cs, sdram, sysc, abort, local_addr
    );
    modport dec (
        input addr, remap, boot_rom, cs_sdram,
        output slave, cs, sdram, sysc, abort, local_addr
    );
endinterface
`default_nettype wire

// File: pkg/bra_pkg.sv
// Types shared by the boot and remap address decoder
package bra_pkg;
    typedef enum logic [2:0] {
        BRA_SLV_NONE,
        BRA_SLV_ROM,
        BRA_SLV_FIRST_SRAM,
        BRA_SLV_SRAM1,
        BRA_SLV_EXT,
        BRA_SLV_APB
    } bra_slave_t;

    typedef enum logic [1:0] {
        BRA_BS_FILL0,
        BRA_BS_FILL1,
        BRA_BS_LATCH,
        BRA_BS_DONE
    } bra_boot_state_t;
endpackage

// File: testbench/bra_master_model.sv
// Bus master model that issues decode requests to the decoder
`timescale 1ns/100ps
`default_nettype none
module bra_master_model #(
    parameter int NM = 2
) (
    output logic [NM-1:0] req_out,
    output logic [NM-1:0][31:0] addr_out
);
    initial begin
        req_out = '0;
        addr_out = '0;
    end

    // ----------------------------------------
    // Request driver
    // ----------------------------------------
    task automatic drive(input logic [NM-1:0] rq,
                         input logic [NM-1:0][31:0] ad);
        for (int g = 0; g < NM; g++) begin
            if (rq[g]) begin
                addr_out[g] = ad[g];
            end else begin
                addr_out[g] = ~addr_out[g];
            end
        end
        req_out = rq;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the boot and remap address decoder
`timescale 1ns/100ps
`default_nettype none
module tb
    import bra_pkg::*;
;
    localparam int NM = 3;
    localparam int NP = 2;
    typedef struct packed {
        logic [2:0] slave;
        logic [7:0] cs;
        logic sdram;
        logic sysc;
        logic abort;
        logic [31:0] loc;
    } bra_exp_t;

    logic clk, rst, pin, remap, boot_cap;
    logic [7:0] sdram_asg;
    logic [NM-1:0] req, dec_valid, sdram, sysc, abort;
    logic [NM-1:0][31:0] addr, local_addr;
    logic [NM-1:0][2:0] slave;
    logic [NM-1:0][7:0] cs;
    logic boot_ready, boot_rom, byte_sel, rw_cs;
    logic [1:0] bus_width;
    int miscompares, comparisons;
    integer seed;
    logic [31:0] corner_tab [20] = '{
        32'h0000_0000, 32'h0000_0FFF, 32'h0000_1000, 32'h0000_7FFF,
        32'h0000_8000, 32'h0010_0000, 32'h0010_7FFF, 32'h0010_8000,
        32'h0020_0FFC, 32'h0020_1000, 32'h0030_0000, 32'h0040_0000,
        32'h1000_0000, 32'h7FFF_FFFF, 32'h8000_0000, 32'hE000_0000,
        32'hF000_0000, 32'hFFFF_E7FF, 32'hFFFF_E800, 32'hFFFF_FFFF};

    bra_master_model #(.NM(NM)) i_bra_master_model (
        .req_out(req), .addr_out(addr));

    bra_decoder_top #(.NUM_MASTERS(NM), .NUM_PROC(NP)) i_bra_decoder_top (
        .SYS_CLK_IN(clk), .RST_IN(rst), .BOOT_MEMORY_SELECT_IN(pin),
        .REMAP_IN(remap), .CS_SDRAM_ASSIGN_IN(sdram_asg), .REQ_IN(req),
        .ADDR_IN(addr), .BOOT_READY_OUT(boot_ready),
        .BOOT_FROM_ROM_OUT(boot_rom),
        .STATIC_MEM_CTRL_BYTE_SEL_OUT(byte_sel),
        .STATIC_MEM_CTRL_WIDTH_OUT(bus_width),
        .STATIC_MEM_CTRL_RW_CS_OUT(rw_cs),
        .DEC_VALID_OUT(dec_valid), .SLAVE_OUT(slave), .CS_OUT(cs),
        .SDRAM_OUT(sdram), .SYSC_OUT(sysc), .ABORT_OUT(abort),
        .LOCAL_ADDR_OUT(local_addr));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    // ----------------------------------------
    // Expected decode
    // ----------------------------------------
    function automatic bra_exp_t expect_dec(int g, logic [31:0] a,
        logic rm, logic bp, logic [7:0] asg);
        bra_exp_t e;
        logic [19:0] off;
        off = a[19:0];
        e = '0;
        e.sysc = (a >= 32'hFFFF_E800);
        if (a[31:28] == 4'h0) begin
            e.loc = {12'h000, off};
            case (a[27:20])
                8'h00: begin
                    if (g < NP && rm) begin
                        if (off < 20'h0_1000) e.slave = BRA_SLV_FIRST_SRAM;
                    end else if (bp) begin
                        if (off < 20'h0_8000) e.slave = BRA_SLV_ROM;
                    end else begin
                        e.slave = BRA_SLV_EXT;
                        e.cs = 8'h01;
                        e.sdram = asg[0];
                    end
                end
                8'h01: if (off < 20'h0_8000) e.slave = BRA_SLV_ROM;
                8'h02: if (off < 20'h0_1000) e.slave = BRA_SLV_FIRST_SRAM;
                8'h03: if (off < 20'h0_1000) e.slave = BRA_SLV_SRAM1;
                default: e.slave = BRA_SLV_NONE;
            endcase
        end else if (a[31:28] <= 4'h7) begin
            e.slave = BRA_SLV_EXT;
            e.cs = 8'h01 << (a[31:28] - 4'h1);
            e.sdram = asg[a[31:28] - 4'h1];
            e.loc = {4'h0, a[27:0]};
        end else if (a[31:28] == 4'hF) begin
            e.slave = BRA_SLV_APB;
            e.loc = a;
        end
        e.abort = (e.slave == BRA_SLV_NONE);
        return e;
    endfunction

    function automatic logic [31:0] rand_addr();
        logic [31:0] a;
        logic [2:0] k;
        a = $random(seed);
        k = 3'($random(seed));
        if (k < 3'h4) begin
            a[31:16] = {4'h0, 6'h00, k[1:0], 4'h0};
        end else if (k == 3'h4) begin
            a[31:12] = 20'hFFFF_E;
        end
        return a;
    endfunction

    // ----------------------------------------
    // Compare, drive and check tasks
    // ----------------------------------------
    task automatic cmp_bit(string nm, logic e, logic s);
        comparisons++;
        if (e !== s) begin
            miscompares++;
            $display("FAIL %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic cmp_vec(string nm, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (e !== s) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic decode(logic [NM-1:0] rq, logic [NM-1:0][31:0] ad,
        logic rm, logic [7:0] asg);
        bra_exp_t e;
        i_bra_master_model.drive(rq, ad);
        remap = rm;
        sdram_asg = asg;
        @(posedge clk);
        #1;
        for (int g = 0; g < NM; g++) begin
            e = expect_dec(g, ad[g], rm, boot_cap, asg);
            cmp_bit("dec_valid", rq[g], dec_valid[g]);
            if (!rq[g]) begin
                e = '0;
            end
            cmp_bit("abort", e.abort, abort[g]);
            cmp_vec("cs", 32'(e.cs), 32'(cs[g]));
            if (rq[g]) begin
                cmp_vec("slave", 32'(e.slave), 32'(slave[g]));
                cmp_bit("sysc", e.sysc, sysc[g]);
                if (!e.abort) cmp_vec("local", e.loc, local_addr[g]);
                if (e.cs != 8'h00) cmp_bit("sdram", e.sdram, sdram[g]);
            end
        end
        #1;
    endtask

    task automatic boot(logic bp);
        logic [NM-1:0][31:0] ad;
        ad = '0;
        rst = 1'b1;
        pin = bp;
        i_bra_master_model.drive('1, ad);
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1;
            cmp_bit("early_valid", 1'b0, dec_valid[0]);
        end
        cmp_bit("boot_ready", 1'b1, boot_ready);
        cmp_bit("boot_rom", bp, boot_rom);
        cmp_bit("byte_sel", ~bp, byte_sel);
        cmp_vec("bus_width", bp ? 32'h0 : 32'h1, 32'(bus_width));
        cmp_bit("rw_cs", ~bp, rw_cs);
        boot_cap = bp;
        #1;
        pin = ~bp;
    endtask

    task automatic corners();
        logic [NM-1:0][31:0] ad;
        ad = '0;
        for (int i = 0; i < 20; i++) begin
            ad = {NM{corner_tab[i]}};
            for (int r = 0; r < 3; r++) begin
                decode('1, ad, r == 1, 8'($random(seed)));
            end
        end
        decode('0, ad, 1'b0, 8'h00);
    endtask

    task automatic random_run(int n);
        logic [NM-1:0][31:0] ad;
        logic [NM-1:0] rq;
        for (int i = 0; i < n; i++) begin
            for (int g = 0; g < NM; g++) ad[g] = rand_addr();
            rq = NM'($random(seed));
            decode(rq, ad, 1'($random(seed)), 8'($random(seed)));
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        pin = 1'b1;
        remap = 1'b0;
        boot_cap = 1'b1;
        sdram_asg = 8'h00;
        seed = 32'hcde1;
        miscompares = 0;
        comparisons = 0;
        #2;
        boot(1'b1);
        corners();
        random_run(150);
        boot(1'b0);
        corners();
        random_run(150);
        end_sim();
    end
endmodule
`default_nettype wire
